// ===== hdl/cbpm_top.v
// pointer manager for the remote-terminal subaddresses set to circular mode two
// assumes a message engine on the same clock and a shared ram that answers
// a read strobe with data in the strobe's own cycle
//
// Operation
// [RULE1] with suppression, interrupt only after clean block
// [RULE2] host picks power-of-two count, one to 512
// [RULE3] host writes count code in control bits 7:4
// [RULE4] size code equals log2 count plus one
// [RULE5] host allocates two info words per message
// [RULE6] host zeroes enough low info pointer bits
// [RULE7] data buffer size may shrink with short messages
// [RULE8] low info pointer bits show message count
// [RULE9] advance info pointer by two per message
// [RULE10] full when incremented low bits all ones
// [RULE11] on full restore info base, copy start
// [RULE12] size code picks low bits to clear
// [RULE13] fetch descriptor chosen by command word first
// [RULE14] receive data stored from current data pointer
// [RULE15] transmit data read from current data pointer
// [RULE16] mid-block pointers sit on next locations
// [RULE17] block interrupt needs descriptor and register enables
// [RULE18] broadcast data shares the normal buffer
// [RULE19] info word carries the broadcast flag
// [RULE20] broadcast transmit sends nothing, pointers unchanged
// [RULE21] host may illegalize broadcasts for subaddress
// [RULE22] completion counts messages, not buffer fill
// [RULE23] mode selected by double off, circular two on
// [RULE24] errors, busy, illegal write info but hold pointers
// [RULE25] host should enable error data suppression
`timescale 1ns/1ps
`default_nettype none
`include "cbpm_defines.vh"

module cbpm_top #(
  parameter ADDR_W = 16
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // host register port
  input wire [1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [15:0] reg_rdata,
  // command from the message engine
  input wire cmd_valid,
  input wire [15:0] cmd_word,
  input wire cmd_broadcast,
  output wire cmd_ready,
  // received data words
  input wire rx_valid,
  input wire [15:0] rx_data,
  output wire rx_ready,
  // words to transmit
  output reg tx_valid,
  output reg [15:0] tx_data,
  input wire tx_ready,
  // end of message with its outcome
  input wire end_valid,
  input wire end_error,
  input wire end_busy,
  input wire end_illegal,
  input wire [15:0] end_time_tag,
  output wire end_ready,
  // shared ram master
  output reg [ADDR_W-1:0] mem_addr,
  output reg [15:0] mem_wdata,
  output reg mem_write,
  output reg mem_read,
  input wire [15:0] mem_rdata,
  // events
  output reg message_irq_output,
  output reg block_done_pulse,
  output reg other_mode_pulse
);

  // ****************************************
  // states
  // ****************************************
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_FETCH = 4'h1;
  localparam [3:0] ST_CHECK = 4'h2;
  localparam [3:0] ST_RX = 4'h3;
  localparam [3:0] ST_TX_RD = 4'h4;
  localparam [3:0] ST_TX_HOLD = 4'h5;
  localparam [3:0] ST_WAIT_END = 4'h6;
  localparam [3:0] ST_WR_INFO = 4'h7;
  localparam [3:0] ST_WR_TAG = 4'h8;
  localparam [3:0] ST_WR_DATA = 4'h9;
  localparam [3:0] ST_WR_PTR = 4'hA;
  localparam [3:0] ST_DONE = 4'hB;

  // ****************************************
  // state
  // ****************************************
  reg [3:0] state;
  reg [2:0] ctrl;
  reg [15:0] table_base;
  reg [15:0] last_info;
  reg [7:0] block_count;
  reg sticky_other;
  reg [15:0] cmd;
  reg broadcast_flag;
  reg [15:0] dw_ctrl;
  reg [ADDR_W-1:0] dw_start;
  reg [ADDR_W-1:0] dw_current;
  reg [ADDR_W-1:0] dw_info;
  reg [2:0] fetch_cnt;
  reg rd_pend;
  reg [1:0] rd_idx;
  reg [5:0] word_cnt;
  reg [15:0] info_word;
  reg [15:0] tag_word;
  reg advance;

  wire [5:0] words_cmd;
  wire is_tx;
  wire broadcast_flag_tx;
  wire mode_two;
  wire [ADDR_W-1:0] desc_addr;
  wire [ADDR_W-1:0] next_info_ptr;
  wire [ADDR_W-1:0] next_data_ptr;
  wire block_full;

  function [ADDR_W-1:0] add_off;
    input [ADDR_W-1:0] base;
    input [5:0] off;
    begin
      add_off = base + {{(ADDR_W-6){1'b0}}, off};
    end
  endfunction

  // a word count field of zero means 32 words
  assign words_cmd = (cmd[`CBPM_CMD_WC_HI:`CBPM_CMD_WC_LO] == 5'h00) ? 6'h20 :
    {1'b0, cmd[`CBPM_CMD_WC_HI:`CBPM_CMD_WC_LO]};
  assign is_tx = cmd[`CBPM_CMD_TR];
  assign broadcast_flag_tx = is_tx && (cmd[`CBPM_CMD_RT_HI:`CBPM_CMD_RT_LO] == `CBPM_BROADCAST_FLAG_RT); // [RULE20]
  assign mode_two = !dw_ctrl[`CBPM_DW_DOUBLE] && dw_ctrl[`CBPM_DW_CIRC_TWO]; // [RULE23]
  // four words per descriptor, picked by direction and subaddress
  assign desc_addr = table_base[ADDR_W-1:0] +
    {{(ADDR_W-8){1'b0}}, cmd[`CBPM_CMD_TR], cmd[`CBPM_CMD_SA_HI:`CBPM_CMD_SA_LO], 2'b00}; // [RULE13]

  assign cmd_ready = (state == ST_IDLE);
  assign rx_ready = (state == ST_RX) && (word_cnt < words_cmd);
  // an end in idle belongs to a message this block did not take and is dropped
  assign end_ready = (state == ST_IDLE) || (state == ST_RX) ||
    (state == ST_TX_HOLD) || (state == ST_WAIT_END);

  cbpm_ptr_update #(
    .ADDR_W(ADDR_W)
  ) u_ptr (
    .info_ptr(dw_info),
    .data_ptr(dw_current),
    .start_ptr(dw_start),
    .size_code(dw_ctrl[`CBPM_DW_SIZE_HI:`CBPM_DW_SIZE_LO]),
    .words_done(word_cnt),
    .next_info_ptr(next_info_ptr),
    .next_data_ptr(next_data_ptr),
    .block_full(block_full)
  );

  // ****************************************
  // host registers
  // ****************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= `CBPM_CTRL_RESET;
      table_base <= `CBPM_TABLE_RESET;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_write && reg_addr == `CBPM_REG_CTRL) begin
        ctrl <= reg_wdata[2:0];
      end
      if (reg_write && reg_addr == `CBPM_REG_TABLE) begin
        table_base <= reg_wdata;
      end
      if (reg_read) begin
        case (reg_addr)
          `CBPM_REG_CTRL: reg_rdata <= {13'h0000, ctrl};
          `CBPM_REG_TABLE: reg_rdata <= table_base;
          `CBPM_REG_STATUS: reg_rdata <= {sticky_other, 3'h0, state, block_count};
          `CBPM_REG_LASTINFO: reg_rdata <= last_info;
          default: reg_rdata <= 16'h0000;
        endcase
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // ****************************************
  // message sequencer
  // ****************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      cmd <= 16'h0000;
      broadcast_flag <= 1'b0;
      dw_ctrl <= 16'h0000;
      dw_start <= {ADDR_W{1'b0}};
      dw_current <= {ADDR_W{1'b0}};
      dw_info <= {ADDR_W{1'b0}};
      fetch_cnt <= 3'h0;
      rd_pend <= 1'b0;
      rd_idx <= 2'h0;
      word_cnt <= 6'h00;
      info_word <= 16'h0000;
      tag_word <= 16'h0000;
      advance <= 1'b0;
      last_info <= 16'h0000;
      block_count <= 8'h00;
      sticky_other <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 16'h0000;
      mem_addr <= {ADDR_W{1'b0}};
      mem_wdata <= 16'h0000;
      mem_write <= 1'b0;
      mem_read <= 1'b0;
      message_irq_output <= 1'b0;
      block_done_pulse <= 1'b0;
      other_mode_pulse <= 1'b0;
    end else begin
      mem_write <= 1'b0;
      mem_read <= 1'b0;
      message_irq_output <= 1'b0;
      block_done_pulse <= 1'b0;
      other_mode_pulse <= 1'b0;
      if (reg_write && reg_addr == `CBPM_REG_STATUS) begin
        sticky_other <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (cmd_valid) begin
            cmd <= cmd_word;
            broadcast_flag <= cmd_broadcast;
            fetch_cnt <= 3'h0;
            rd_pend <= 1'b0;
            word_cnt <= 6'h00;
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // one read per cycle, each word caught at the edge that closes its strobe cycle
          if (fetch_cnt < 3'h4) begin
            mem_addr <= add_off(desc_addr, {4'h0, fetch_cnt[1:0]}); // [RULE13]
            mem_read <= 1'b1;
            rd_idx <= fetch_cnt[1:0];
            fetch_cnt <= fetch_cnt + 3'h1;
          end
          rd_pend <= (fetch_cnt < 3'h4);
          if (rd_pend) begin
            case (rd_idx)
              `CBPM_DESC_CTRL: dw_ctrl <= mem_rdata;
              `CBPM_DESC_START: dw_start <= mem_rdata[ADDR_W-1:0];
              `CBPM_DESC_CURRENT: dw_current <= mem_rdata[ADDR_W-1:0];
              default: dw_info <= mem_rdata[ADDR_W-1:0];
            endcase
            if (rd_idx == `CBPM_DESC_INFO) begin
              state <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          if (!mode_two) begin
            // another buffer mode owns this subaddress
            other_mode_pulse <= 1'b1;
            sticky_other <= 1'b1;
            state <= ST_IDLE;
          end else if (broadcast_flag_tx) begin
            state <= ST_WAIT_END; // [RULE20]
          end else if (is_tx) begin
            state <= ST_TX_RD;
          end else begin
            // segregation setting has no effect in this mode
            state <= ST_RX; // [RULE18]
          end
        end
        ST_RX: begin
          if (rx_valid && rx_ready) begin
            mem_addr <= add_off(dw_current, word_cnt); // [RULE14] [RULE18]
            mem_wdata <= rx_data;
            mem_write <= 1'b1;
            word_cnt <= word_cnt + 6'h01;
          end
        end
        ST_TX_RD: begin
          mem_addr <= add_off(dw_current, word_cnt); // [RULE15]
          mem_read <= 1'b1;
          state <= ST_TX_HOLD;
          rd_pend <= 1'b1;
        end
        ST_TX_HOLD: begin
          rd_pend <= 1'b0;
          if (rd_pend) begin
            tx_data <= mem_rdata;
            tx_valid <= 1'b1;
          end else if (tx_valid && tx_ready) begin
            tx_valid <= 1'b0;
            word_cnt <= word_cnt + 6'h01;
            state <= (word_cnt + 6'h01 < words_cmd) ? ST_TX_RD : ST_WAIT_END;
          end
        end
        ST_WAIT_END: begin
        end
        ST_WR_INFO: begin
          mem_addr <= dw_info;
          mem_wdata <= info_word;
          mem_write <= 1'b1;
          last_info <= info_word;
          state <= ST_WR_TAG;
        end
        ST_WR_TAG: begin
          mem_addr <= add_off(dw_info, 6'h01);
          mem_wdata <= tag_word;
          mem_write <= 1'b1;
          state <= advance ? ST_WR_DATA : ST_IDLE; // [RULE24] [RULE20]
        end
        ST_WR_DATA: begin
          mem_addr <= add_off(desc_addr, {4'h0, `CBPM_DESC_CURRENT});
          mem_wdata <= {{(16-ADDR_W){1'b0}}, next_data_ptr}; // [RULE11] [RULE16]
          mem_write <= 1'b1;
          state <= ST_WR_PTR;
        end
        ST_WR_PTR: begin
          mem_addr <= add_off(desc_addr, {4'h0, `CBPM_DESC_INFO});
          mem_wdata <= {{(16-ADDR_W){1'b0}}, next_info_ptr}; // [RULE9] [RULE11]
          mem_write <= 1'b1;
          state <= ST_DONE;
        end
        ST_DONE: begin
          // completion follows the message count only, never the data fill
          if (block_full) begin // [RULE22]
            block_done_pulse <= 1'b1;
            block_count <= block_count + 8'h01;
            // errored messages never advance, so a block holds only clean ones
            message_irq_output <= dw_ctrl[`CBPM_DW_IRQ_EN] && ctrl[`CBPM_CTRL_IRQ_EN]; // [RULE17] [RULE1]
          end
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // message end closes the data phase from any waiting state
      if (end_valid && end_ready && state != ST_IDLE) begin
        tx_valid <= 1'b0;
        info_word <= {16{1'b0}};
        info_word[`CBPM_INFO_BROADCAST_FLAG] <= broadcast_flag; // [RULE19]
        info_word[`CBPM_INFO_ERROR] <= end_error;
        info_word[`CBPM_INFO_BUSY] <= end_busy;
        info_word[`CBPM_INFO_ILLEGAL] <= end_illegal;
        info_word[`CBPM_INFO_TR] <= is_tx;
        info_word[`CBPM_CMD_WC_HI:`CBPM_CMD_WC_LO] <= cmd[`CBPM_CMD_WC_HI:`CBPM_CMD_WC_LO];
        tag_word <= end_time_tag;
        advance <= !(end_error || end_busy || end_illegal || broadcast_flag_tx); // [RULE24] [RULE20]
        state <= ST_WR_INFO;
      end
    end
  end

endmodule // cbpm_top

`default_nettype wire

// ===== hdl/cbpm_defines.vh
// constants for the circular buffer mode two pointer manager
// assumes 16-bit shared ram words and a word-addressed descriptor table
`ifndef CBPM_DEFINES_VH
`define CBPM_DEFINES_VH

// ****************************************
// host register offsets (2-bit index)
// ****************************************
`define CBPM_REG_CTRL 2'h0
`define CBPM_REG_TABLE 2'h1
`define CBPM_REG_STATUS 2'h2
`define CBPM_REG_LASTINFO 2'h3

// ****************************************
// control register fields and reset value
// ****************************************
`define CBPM_CTRL_SUPPRESS 0
`define CBPM_CTRL_IRQ_EN 1
`define CBPM_CTRL_SEGREGATE 2
`define CBPM_CTRL_RESET 3'h0
`define CBPM_TABLE_RESET 16'h0000

// ****************************************
// descriptor layout
// ****************************************
`define CBPM_DESC_CTRL 2'h0
`define CBPM_DESC_START 2'h1
`define CBPM_DESC_CURRENT 2'h2
`define CBPM_DESC_INFO 2'h3
`define CBPM_DW_IRQ_EN 8
`define CBPM_DW_CIRC_TWO 3
`define CBPM_DW_DOUBLE 2
`define CBPM_DW_SIZE_HI 7
`define CBPM_DW_SIZE_LO 4

// ****************************************
// command word and information word fields
// ****************************************
`define CBPM_CMD_RT_HI 15
`define CBPM_CMD_RT_LO 11
`define CBPM_CMD_TR 10
`define CBPM_CMD_SA_HI 9
`define CBPM_CMD_SA_LO 5
`define CBPM_CMD_WC_HI 4
`define CBPM_CMD_WC_LO 0
`define CBPM_BROADCAST_FLAG_RT 5'h1F
`define CBPM_INFO_BROADCAST_FLAG 15
`define CBPM_INFO_ERROR 14
`define CBPM_INFO_BUSY 13
`define CBPM_INFO_ILLEGAL 12
`define CBPM_INFO_TR 10

`endif

// ===== hdl/cbpm_ptr_update.v
// next-pointer arithmetic for one completed message
// assumes the information pointer base carries enough trailing zeros
`timescale 1ns/1ps
`default_nettype none

module cbpm_ptr_update #(
  parameter ADDR_W = 16
) (
  // pointers from the descriptor
  input wire [ADDR_W-1:0] info_ptr,
  input wire [ADDR_W-1:0] data_ptr,
  input wire [ADDR_W-1:0] start_ptr,
  // message facts
  input wire [3:0] size_code,
  input wire [5:0] words_done,
  // results
  output reg [ADDR_W-1:0] next_info_ptr,
  output reg [ADDR_W-1:0] next_data_ptr,
  output reg block_full
);

  reg [ADDR_W-1:0] low_mask;
  reg [ADDR_W-1:0] once;
  integer i;

  always @* begin
    // the size code is the number of low pointer bits that count messages
    low_mask = {ADDR_W{1'b0}};
    for (i = 0; i < ADDR_W; i = i + 1) begin
      if (i < size_code) begin
        low_mask[i] = 1'b1; // [RULE12]
      end
    end
    once = info_ptr + {{(ADDR_W-1){1'b0}}, 1'b1};
    block_full = ((once & low_mask) == low_mask); // [RULE10] [RULE4]
    if (block_full) begin
      next_info_ptr = info_ptr & ~low_mask; // [RULE11]
      next_data_ptr = start_ptr; // [RULE11]
    end else begin
      next_info_ptr = info_ptr + {{(ADDR_W-2){1'b0}}, 2'b10}; // [RULE9] [RULE8]
      next_data_ptr = data_ptr + {{(ADDR_W-6){1'b0}}, words_done}; // [RULE16]
    end
  end

endmodule // cbpm_ptr_update

`default_nettype wire

// ===== dv/cbpm_checker.sv
// port assertions for the circular mode two pointer manager
// assumes one clock domain and an active-high asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module cbpm_checker #(
  parameter ADDR_W = 16
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // host port
  input wire [1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  // message engine
  input wire cmd_valid,
  input wire [15:0] cmd_word,
  input wire cmd_broadcast,
  input wire cmd_ready,
  input wire rx_valid,
  input wire [15:0] rx_data,
  input wire rx_ready,
  input wire tx_valid,
  input wire [15:0] tx_data,
  input wire tx_ready,
  input wire end_valid,
  input wire end_error,
  input wire end_busy,
  input wire end_illegal,
  input wire end_ready,
  // ram and events
  input wire [ADDR_W-1:0] mem_addr,
  input wire [15:0] mem_wdata,
  input wire mem_write,
  input wire mem_read,
  input wire message_irq_output,
  input wire block_done_pulse
);
  // ****
  // shadow state
  // ****
  logic [15:0] base;
  logic [15:0] cwq;
  logic [15:0] rxq;
  logic [1:0] ctl;
  logic bcq;
  logic btx;
  logic bad;
  logic ended;
  logic [2:0] wcnt;
  wire take = cmd_valid && cmd_ready;
  wire fin = end_valid && end_ready && !cmd_ready;
  wire [15:0] dsc = base + {8'h00, cwq[10:5], 2'b00};

  // write counts only follow transmit ends: receive data writes may trail the end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      base <= 16'h0000;
      cwq <= 16'h0000;
      rxq <= 16'h0000;
      ctl <= 2'h0;
      bcq <= 1'b0;
      btx <= 1'b0;
      bad <= 1'b0;
      ended <= 1'b0;
      wcnt <= 3'h0;
    end else begin
      if (reg_write && reg_addr == 2'h1) base <= reg_wdata;
      if (reg_write && reg_addr == 2'h0) ctl <= reg_wdata[1:0];
      if (rx_valid && rx_ready) rxq <= rx_data;
      if (take) begin
        cwq <= cmd_word;
        bcq <= cmd_broadcast;
        btx <= cmd_word[15:11] == 5'h1F && cmd_word[10];
      end else if (cmd_ready) begin
        btx <= 1'b0;
        ended <= 1'b0;
      end
      if (fin) begin
        bad <= end_error || end_busy || end_illegal || btx;
        ended <= cwq[10];
        wcnt <= 3'h0;
      end else if (ended && mem_write) begin
        wcnt <= wcnt + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_desc_fetch: assert property (take |-> ##[1:2] (mem_read && mem_addr == dsc))
    else $error("descriptor read address wrong");
  chk_idle_no_rx: assert property (cmd_ready |-> !rx_ready)
    else $error("receive ready while idle");
  chk_rx_store: assert property (rx_valid && rx_ready |->
    ##[1:2] (mem_write && mem_wdata == rxq)) else $error("received word not stored");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("transmit word dropped");
  chk_btx_silent: assert property (btx |-> !tx_valid)
    else $error("broadcast transmit sent data");
  chk_end_writes: assert property ($rose(cmd_ready) && ended |->
    (wcnt + {2'b00, mem_write}) == (bad ? 3'h2 : 3'h4))
    else $error("wrong write count after message end");
  chk_info_broadcast_flag: assert property (ended && wcnt == 3'h0 && mem_write |->
    mem_wdata[15] == bcq) else $error("information word broadcast flag wrong");
  chk_irq_gate: assert property (message_irq_output |-> block_done_pulse && ctl[1])
    else $error("interrupt without completion or enable");
  chk_done_clean: assert property (block_done_pulse |-> !bad)
    else $error("block completed on a failed message");

  cov_irq: cover property (message_irq_output);
  cov_btx: cover property (btx && fin);
  cov_stall: cover property (tx_valid && !tx_ready);
endmodule // cbpm_checker

bind cbpm_top cbpm_checker #(.ADDR_W(ADDR_W)) chk (.*);
`default_nettype wire

// ===== dv/cbpm_ram_model.sv
// shared ram seen by the pointer manager, read data in the strobe's own cycle
// assumes the bench preloads and inspects the array directly
`timescale 1ns/1ps
`default_nettype none
module cbpm_ram_model (
  // clock
  input wire logic clk,
  // ram port
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_write,
  input wire logic mem_read,
  output logic [15:0] mem_rdata
);
  logic [15:0] m [0:4095];
  always @(posedge clk) begin
    if (mem_write) m[mem_addr[11:0]] <= mem_wdata;
  end
  // the manager latches the word at the edge that closes its strobe cycle,
  // so data stand only while the strobe does; otherwise a wrong word shows
  assign mem_rdata = mem_read ? m[mem_addr[11:0]] : ~m[mem_addr[11:0]];
endmodule // cbpm_ram_model
`default_nettype wire

// ===== dv/cbpm_top_tb.sv
// self-checking bench for the circular mode two pointer manager
// assumes the ram model shows read data in the strobe's own cycle
`timescale 1ns/1ps
`default_nettype none
module cbpm_top_tb;
  logic clk, reset, reg_write, reg_read, cmd_valid, cmd_broadcast, cmd_ready;
  logic rx_valid, rx_ready, tx_valid, tx_ready, end_valid, end_error, end_busy;
  logic end_illegal, end_ready, mem_write, mem_read;
  logic message_irq_output, block_done_pulse, other_mode_pulse;
  logic [1:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, cmd_word, rx_data, tx_data, end_time_tag;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [15:0] wq [0:1];
  logic [15:0] tq [0:3];
  int err_count, compares, irqs, dones, others, ntx, nwant;
  cbpm_top DUT (.*);
  cbpm_ram_model ram (.*);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (message_irq_output === 1'b1) irqs++;
    if (block_done_pulse === 1'b1) dones++;
    if (other_mode_pulse === 1'b1) others++;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      tq[ntx] = tx_data;
      ntx++;
    end
  end

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  function automatic logic rdy(input int s);
    case (s)
      0: return cmd_ready;
      1: return rx_ready;
      2: return end_ready;
      3: return others > 0;
      4: return ntx == nwant;
      default: return tx_valid;
    endcase
  endfunction
  task automatic hold_for(input int s);
    int i;
    #1;
    for (i = 0; i < 64 && rdy(s) !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 64) begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic desc(input logic [11:0] a, input logic [15:0] c, s, b);
    ram.m[a] = c;
    ram.m[a + 12'h1] = s;
    ram.m[a + 12'h2] = s;
    ram.m[a + 12'h3] = b;
  endtask
  task automatic msg(input logic [15:0] cw, input logic bc, er, input logic [15:0] tg);
    int k;
    ntx = 0;
    nwant = (cw[10] && cw[15:11] != 5'h1F) ? int'(cw[4:0]) : 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_word <= cw;
    cmd_broadcast <= bc;
    hold_for(0);
    @(posedge clk);
    cmd_valid <= 1'b0;
    if (!cw[10]) begin
      for (k = 0; k < int'(cw[4:0]); k++) begin
        rx_valid <= 1'b1;
        rx_data <= wq[k];
        hold_for(1);
        @(posedge clk);
      end
      rx_valid <= 1'b0;
    end else begin
      // hold off the first transmit word one cycle to exercise the stall
      if (nwant > 0) begin
        hold_for(5);
        @(posedge clk);
        tx_ready <= 1'b1;
      end
      hold_for(4);
      @(posedge clk);
    end
    end_valid <= 1'b1;
    end_error <= er;
    end_time_tag <= tg;
    hold_for(2);
    @(posedge clk);
    end_valid <= 1'b0;
    tx_ready <= 1'b0;
    hold_for(0);
    // let the last ram write land and the event counters see the done pulse
    @(posedge clk);
    #1;
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_regs;
    logic [15:0] v;
    rd(2'h0, v);
    chk("ctrl reset", 16'h0000, v);
    wr(2'h0, 16'h0003);
    wr(2'h1, 16'h0200);
    rd(2'h1, v);
    chk("table base", 16'h0200, v);
  endtask
  task automatic t_rx_block;
    desc(12'h204, 16'h0128, 16'h0400, 16'h0100);
    wq[0] = 16'hA001;
    wq[1] = 16'hA002;
    msg(16'h2822, 1'b0, 1'b0, 16'h1111);
    chk("rx word 0", 16'hA001, ram.m[12'h400]);
    chk("rx word 1", 16'hA002, ram.m[12'h401]);
    chk("info 0", 16'h0002, ram.m[12'h100]);
    chk("tag 0", 16'h1111, ram.m[12'h101]);
    chk("data ptr 0", 16'h0402, ram.m[12'h206]);
    chk("info ptr 0", 16'h0102, ram.m[12'h207]);
    wq[0] = 16'hB001;
    msg(16'h2821, 1'b0, 1'b1, 16'h2222);
    chk("info err", 16'h4001, ram.m[12'h102]);
    chk("info ptr err", 16'h0102, ram.m[12'h207]);
    chk("data ptr err", 16'h0402, ram.m[12'h206]);
    chk("dones early", 16'h0000, 16'(dones));
    wq[0] = 16'hC001;
    msg(16'hF821, 1'b1, 1'b0, 16'h3333);
    chk("broadcast_flag word", 16'hC001, ram.m[12'h402]);
    chk("broadcast_flag info", 16'h8001, ram.m[12'h102]);
    chk("broadcast_flag tag", 16'h3333, ram.m[12'h103]);
    chk("info ptr wrap", 16'h0100, ram.m[12'h207]);
    chk("data ptr wrap", 16'h0400, ram.m[12'h206]);
    chk("dones", 16'h0001, 16'(dones));
    chk("irqs", 16'h0001, 16'(irqs));
    wr(2'h0, 16'h0001);
    msg(16'h2821, 1'b0, 1'b0, 16'h4444);
    msg(16'h2821, 1'b0, 1'b0, 16'h5555);
    chk("dones masked", 16'h0002, 16'(dones));
    chk("irqs masked", 16'h0001, 16'(irqs));
    @(posedge clk);
    end_illegal <= 1'b1;
    msg(16'hF821, 1'b1, 1'b0, 16'h6060);
    chk("illegal info", 16'h9001, ram.m[12'h100]);
    chk("illegal info ptr", 16'h0100, ram.m[12'h207]);
    chk("illegal data ptr", 16'h0400, ram.m[12'h206]);
    @(posedge clk);
    end_illegal <= 1'b0;
  endtask
  task automatic t_tx;
    desc(12'h284, 16'h0028, 16'h0500, 16'h0140);
    ram.m[12'h500] = 16'hD001;
    ram.m[12'h501] = 16'hD002;
    msg(16'hFC22, 1'b1, 1'b0, 16'h6666);
    chk("btx words", 16'h0000, 16'(ntx));
    chk("btx info", 16'h8402, ram.m[12'h140]);
    chk("btx info ptr", 16'h0140, ram.m[12'h287]);
    chk("btx data ptr", 16'h0500, ram.m[12'h286]);
    msg(16'h2C22, 1'b0, 1'b0, 16'h7777);
    chk("tx word 0", 16'hD001, tq[0]);
    chk("tx word 1", 16'hD002, tq[1]);
    chk("tx info", 16'h0402, ram.m[12'h140]);
    chk("tx tag", 16'h7777, ram.m[12'h141]);
    chk("tx data ptr", 16'h0502, ram.m[12'h286]);
    chk("tx info ptr", 16'h0142, ram.m[12'h287]);
  endtask
  task automatic t_other;
    logic [15:0] v;
    chk("no other", 16'h0000, 16'(others));
    desc(12'h208, 16'h000C, 16'h0600, 16'h0180);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_word <= 16'h2841;
    cmd_broadcast <= 1'b0;
    hold_for(0);
    @(posedge clk);
    cmd_valid <= 1'b0;
    hold_for(3);
    rd(2'h2, v);
    chk("other sticky", 16'h0001, {15'h0000, v[15]});
  endtask

  initial begin
    reset = 1'b1;
    {reg_write, reg_read, cmd_valid, cmd_broadcast, rx_valid, tx_ready} = 6'h00;
    {end_valid, end_error, end_busy, end_illegal} = 4'h0;
    reg_addr = 2'h0;
    reg_wdata = 16'h0000;
    cmd_word = 16'h0000;
    rx_data = 16'h0000;
    end_time_tag = 16'h0000;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_rx_block();
    t_tx();
    t_other();
    report_and_stop();
  end
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule // cbpm_top_tb
`default_nettype wire
